/* hw/sgc_pkg.sv */
package sgc_pkg;

  // register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int NUM_SW_PORTS = 2;
  localparam int NUM_FWD_PORTS = 3;

  // byte offsets of the 16-bit registers
  localparam logic [11:0] OFS_GCTRL7 = 12'h00E;
  localparam logic [11:0] OFS_PSA_HIGH = 12'h010;
  localparam logic [11:0] OFS_PSA_MID = 12'h012;
  localparam logic [11:0] OFS_PSA_LOW = 12'h014;
  localparam logic [11:0] OFS_P1_LED_CTRL = 12'h06C;
  localparam logic [11:0] OFS_P2_LED_CTRL = 12'h084;

  // global control word fields
  localparam int GC_RSVD_HI_MSB = 15;
  localparam int GC_RSVD_HI_LSB = 10;
  localparam int GC_LED_MODE_MSB = 9;
  localparam int GC_LED_MODE_LSB = 8;
  localparam int GC_UNK_EN_BIT = 7;
  localparam int GC_DRIVE_MSB = 6;
  localparam int GC_DRIVE_LSB = 5;
  localparam int GC_RSVD_LO_MSB = 4;
  localparam int GC_RSVD_LO_LSB = 3;
  localparam int GC_UNK_MASK_MSB = 2;
  localparam int GC_UNK_MASK_LSB = 0;

  // global control reset values
  localparam logic [5:0] GC_RSVD_HI_RST = 6'h02;
  localparam logic [1:0] GC_LED_MODE_RST = 2'h0;
  localparam logic GC_UNK_EN_RST = 1'b0;
  localparam logic [1:0] GC_DRIVE_RST_HV = 2'h1;
  localparam logic [1:0] GC_DRIVE_RST_LV = 2'h2;
  localparam logic [1:0] GC_RSVD_LO_RST = 2'h0;
  localparam logic [2:0] GC_UNK_MASK_RST = 3'h7;

  // per-port led control register fields
  localparam int LC_SEL_MSB = 14;
  localparam int LC_SEL_LSB = 12;
  localparam int LC_MAN_MSB = 1;
  localparam int LC_MAN_LSB = 0;
  localparam logic [2:0] LC_SEL_AUTO = 3'h0;
  localparam logic [15:0] LC_RST = 16'h0000;

  // arbitrary neutral station address, not tied to any maker
  localparam logic [47:0] PSA_RST = 48'h0200_0000_0001;

  typedef enum logic [1:0] {
    SGC_LED_SPD_LNKACT,
    SGC_LED_ACT_LNK,
    SGC_LED_FDX_LNKACT,
    SGC_LED_FDX_LNK
  } sgc_led_mode_e;

  typedef struct packed {
    logic [5:0] rsvd_hi;
    sgc_led_mode_e led_mode;
    logic unk_en;
    logic [1:0] drive;
    logic [1:0] rsvd_lo;
    logic [2:0] unk_mask;
  } sgc_gctrl_s;

  typedef struct packed {
    logic link;
    logic activity;
    logic speed100;
    logic full_duplex;
  } sgc_port_stat_s;

  typedef struct packed {
    logic valid;
    logic [1:0] src_port;
  } sgc_miss_s;

endpackage

/* hw/sgc_led_mux.sv */
`timescale 1ns/1ps

module sgc_led_mux (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // settings
  input wire sgc_pkg::sgc_led_mode_e mode,
  input wire logic [2:0] sel,
  input wire logic [1:0] manual,
  // port status
  input wire sgc_pkg::sgc_port_stat_s stat,
  // led drive
  output logic port_led_out_one,
  output logic port_led_out_zero
);

  logic one_nxt;
  logic zero_nxt;
  logic lnk_act;

  // lit on link, blinked off while traffic passes
  assign lnk_act = stat.link & ~stat.activity;

  always_comb begin
    one_nxt = 1'b0;
    zero_nxt = 1'b0;
    if (sel != sgc_pkg::LC_SEL_AUTO) begin
      one_nxt = manual[1];
      zero_nxt = manual[0];
    end else begin
      unique case (mode)
        sgc_pkg::SGC_LED_SPD_LNKACT: begin
          one_nxt = stat.speed100;
          zero_nxt = lnk_act;
        end
        sgc_pkg::SGC_LED_ACT_LNK: begin
          one_nxt = stat.activity;
          zero_nxt = stat.link;
        end
        sgc_pkg::SGC_LED_FDX_LNKACT: begin
          one_nxt = stat.full_duplex;
          zero_nxt = lnk_act;
        end
        sgc_pkg::SGC_LED_FDX_LNK: begin
          one_nxt = stat.full_duplex;
          zero_nxt = stat.link;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_led_out_one <= 1'b0;
      port_led_out_zero <= 1'b0;
    end else begin
      port_led_out_one <= one_nxt;
      port_led_out_zero <= zero_nxt;
    end
  end

endmodule

/* hw/sgc_top.sv */
`timescale 1ns/1ps

module sgc_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic io_low_voltage,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // port status and leds
  input wire sgc_pkg::sgc_port_stat_s [1:0] port_stat,
  output logic [1:0] port_led_out_one,
  output logic [1:0] port_led_out_zero,
  // forwarding engine
  input wire sgc_pkg::sgc_miss_s lookup_miss,
  output logic fwd_valid,
  output logic [2:0] fwd_mask,
  // pause generator and pads
  output logic [47:0] pause_station_address,
  output logic [1:0] drive_strength
);

  sgc_pkg::sgc_gctrl_s gctrl_r;
  sgc_pkg::sgc_gctrl_s gctrl_nxt;
  logic [15:0] psa_hi_r;
  logic [15:0] psa_hi_nxt;
  logic [15:0] psa_mid_r;
  logic [15:0] psa_mid_nxt;
  logic [15:0] psa_lo_r;
  logic [15:0] psa_lo_nxt;
  logic [15:0] ledc_r [2];
  logic [15:0] ledc_nxt [2];
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic fwd_valid_r;
  logic fwd_valid_nxt;
  logic [2:0] fwd_mask_r;
  logic [2:0] fwd_mask_nxt;
  logic [47:0] psa_out_r;
  logic [47:0] psa_out_nxt;
  logic [2:0] flood_mask;

  // register writes
  always_comb begin
    gctrl_nxt = gctrl_r;
    psa_hi_nxt = psa_hi_r;
    psa_mid_nxt = psa_mid_r;
    psa_lo_nxt = psa_lo_r;
    ledc_nxt[0] = ledc_r[0];
    ledc_nxt[1] = ledc_r[1];
    if (reg_wr) begin
      unique case (reg_addr)
        sgc_pkg::OFS_GCTRL7: begin
          // reserved fields are stored as written
          gctrl_nxt = sgc_pkg::sgc_gctrl_s'(reg_wdata);
        end
        sgc_pkg::OFS_PSA_HIGH: begin
          psa_hi_nxt = reg_wdata;
        end
        sgc_pkg::OFS_PSA_MID: begin
          psa_mid_nxt = reg_wdata;
        end
        sgc_pkg::OFS_PSA_LOW: begin
          psa_lo_nxt = reg_wdata;
        end
        sgc_pkg::OFS_P1_LED_CTRL: begin
          ledc_nxt[0] = reg_wdata;
        end
        sgc_pkg::OFS_P2_LED_CTRL: begin
          ledc_nxt[1] = reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gctrl_r.rsvd_hi <= sgc_pkg::GC_RSVD_HI_RST;
      gctrl_r.led_mode <= sgc_pkg::sgc_led_mode_e'(sgc_pkg::GC_LED_MODE_RST);
      gctrl_r.unk_en <= sgc_pkg::GC_UNK_EN_RST;
      // pad supply level chosen by strap, caught in the reset cycle
      gctrl_r.drive <= io_low_voltage ? sgc_pkg::GC_DRIVE_RST_LV
                                      : sgc_pkg::GC_DRIVE_RST_HV;
      gctrl_r.rsvd_lo <= sgc_pkg::GC_RSVD_LO_RST;
      gctrl_r.unk_mask <= sgc_pkg::GC_UNK_MASK_RST;
      psa_hi_r <= sgc_pkg::PSA_RST[47:32];
      psa_mid_r <= sgc_pkg::PSA_RST[31:16];
      psa_lo_r <= sgc_pkg::PSA_RST[15:0];
      ledc_r[0] <= sgc_pkg::LC_RST;
      ledc_r[1] <= sgc_pkg::LC_RST;
    end else begin
      gctrl_r <= gctrl_nxt;
      psa_hi_r <= psa_hi_nxt;
      psa_mid_r <= psa_mid_nxt;
      psa_lo_r <= psa_lo_nxt;
      ledc_r[0] <= ledc_nxt[0];
      ledc_r[1] <= ledc_nxt[1];
    end
  end

  // register reads, data only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        sgc_pkg::OFS_GCTRL7: begin
          rdata_nxt = gctrl_r;
        end
        sgc_pkg::OFS_PSA_HIGH: begin
          rdata_nxt = psa_hi_r;
        end
        sgc_pkg::OFS_PSA_MID: begin
          rdata_nxt = psa_mid_r;
        end
        sgc_pkg::OFS_PSA_LOW: begin
          rdata_nxt = psa_lo_r;
        end
        sgc_pkg::OFS_P1_LED_CTRL: begin
          rdata_nxt = ledc_r[0];
        end
        sgc_pkg::OFS_P2_LED_CTRL: begin
          rdata_nxt = ledc_r[1];
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // forwarding decision for a destination missing from the table;
  // when disabled, the frame floods every port but its source
  always_comb begin
    flood_mask = 3'h7;
    if (lookup_miss.src_port < 2'h3) begin
      flood_mask[lookup_miss.src_port] = 1'b0;
    end
  end

  always_comb begin
    fwd_valid_nxt = lookup_miss.valid;
    fwd_mask_nxt = fwd_mask_r;
    if (lookup_miss.valid) begin
      if (gctrl_r.unk_en) begin
        fwd_mask_nxt = gctrl_r.unk_mask;
      end else begin
        fwd_mask_nxt = flood_mask;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fwd_valid_r <= 1'b0;
      fwd_mask_r <= 3'h0;
    end else begin
      fwd_valid_r <= fwd_valid_nxt;
      fwd_mask_r <= fwd_mask_nxt;
    end
  end

  assign fwd_valid = fwd_valid_r;
  assign fwd_mask = fwd_mask_r;

  // source address for outgoing pause frames, follows writes two cycles after the strobe
  always_comb begin
    psa_out_nxt = {psa_hi_r, psa_mid_r, psa_lo_r};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      psa_out_r <= sgc_pkg::PSA_RST;
    end else begin
      psa_out_r <= psa_out_nxt;
    end
  end

  assign pause_station_address = psa_out_r;
  assign drive_strength = gctrl_r.drive;

  // per-port led drivers
  generate
    for (genvar p = 0; p < sgc_pkg::NUM_SW_PORTS; p++) begin : g_led
      sgc_led_mux i_sgc_led_mux (
        .sys_clk(sys_clk),
        .rst(rst),
        .mode(gctrl_r.led_mode),
        .sel(ledc_r[p][sgc_pkg::LC_SEL_MSB:sgc_pkg::LC_SEL_LSB]),
        .manual(ledc_r[p][sgc_pkg::LC_MAN_MSB:sgc_pkg::LC_MAN_LSB]),
        .stat(port_stat[p]),
        .port_led_out_one(port_led_out_one[p]),
        .port_led_out_zero(port_led_out_zero[p])
      );
    end
  endgenerate

endmodule

/* tb/sgc_props.sv */
`timescale 1ns/1ps

module sgc_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic io_low_voltage,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // forwarding, pause and pads
  input wire sgc_pkg::sgc_miss_s lookup_miss,
  input wire logic fwd_valid,
  input wire logic [2:0] fwd_mask,
  input wire logic [47:0] pause_station_address,
  input wire logic [1:0] drive_strength
);
  logic [15:0] gc_r;
  logic [15:0] gc_nxt;
  // shadow of the control word, strap picks the reset drive
  always_comb begin
    gc_nxt = gc_r;
    if (reg_wr && reg_addr == sgc_pkg::OFS_GCTRL7)
      gc_nxt = reg_wdata;
    if (rst)
      gc_nxt = io_low_voltage ? 16'h0847 : 16'h0827;
  end
  always_ff @(posedge sys_clk) gc_r <= gc_nxt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  gctrl_read_a: assert property (
    $past(reg_rd && reg_addr == sgc_pkg::OFS_GCTRL7)
      |-> reg_rdata == $past(gc_r))
    else $error("control word read wrong");
  fwd_pulse_a: assert property (lookup_miss.valid |=> fwd_valid)
    else $error("miss not forwarded");
  fwd_only_a: assert property (fwd_valid |-> $past(lookup_miss.valid))
    else $error("forward without miss");
  fwd_mask_a: assert property (
    lookup_miss.valid |=> fwd_mask == ($past(gc_r[7]) ? $past(gc_r[2:0])
      : 3'h7 & ~(3'h1 << $past(lookup_miss.src_port))))
    else $error("forward mask wrong");
  psa_high_a: assert property (
    reg_wr && reg_addr == sgc_pkg::OFS_PSA_HIGH
      |-> ##2 pause_station_address[47:32] == $past(reg_wdata, 2))
    else $error("address high word wrong");
  psa_mid_a: assert property (
    reg_wr && reg_addr == sgc_pkg::OFS_PSA_MID
      |-> ##2 pause_station_address[31:16] == $past(reg_wdata, 2))
    else $error("address mid word wrong");
  psa_low_a: assert property (
    reg_wr && reg_addr == sgc_pkg::OFS_PSA_LOW
      |-> ##2 pause_station_address[15:0] == $past(reg_wdata, 2))
    else $error("address low word wrong");
  drive_strength_a: assert property (drive_strength == gc_r[6:5])
    else $error("drive strength wrong");
  cover property (lookup_miss.valid && gc_r[7]);
  cover property (reg_wr && reg_addr == sgc_pkg::OFS_GCTRL7);
  cover property (reg_wr && reg_addr == sgc_pkg::OFS_PSA_LOW);
endmodule

bind sgc_top sgc_props i_sgc_props (.sys_clk, .rst, .io_low_voltage,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lookup_miss,
  .fwd_valid, .fwd_mask, .pause_station_address, .drive_strength);

/* tb/tb_sgc_top.sv */
`timescale 1ns/1ps

module tb_sgc_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic io_low_voltage = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  sgc_pkg::sgc_port_stat_s [1:0] port_stat = '0;
  logic [1:0] led_one;
  logic [1:0] led_zero;
  sgc_pkg::sgc_miss_s lookup_miss = '0;
  logic fwd_valid;
  logic [2:0] fwd_mask;
  logic [47:0] psa;
  logic [1:0] drive_strength;
  logic rd_pend = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] w;
  logic [47:0] mac = '0;
  int err_count = 0;
  int checks_done = 0;
  int seed = 28;

  always #20 sys_clk = ~sys_clk;

  sgc_top i_sgc_top (.sys_clk, .rst, .io_low_voltage, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_stat,
    .port_led_out_one(led_one), .port_led_out_zero(led_zero),
    .lookup_miss, .fwd_valid, .fwd_mask,
    .pause_station_address(psa), .drive_strength);

  task automatic stop_test;
    $display("err_count=%0d checks_done=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) rd_pend <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_pend)
      chk(48'(reg_rdata), 48'(exp_q.pop_front()));
  end

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic miss(input logic [1:0] p, input logic [2:0] m);
    @(posedge sys_clk);
    lookup_miss <= '{valid: 1'b1, src_port: p};
    @(posedge sys_clk);
    lookup_miss.valid <= 1'b0;
    @(negedge sys_clk);
    chk(48'(fwd_valid), 48'h1);
    chk(48'(fwd_mask), 48'(m));
  endtask

  function automatic logic [1:0] led_exp(input logic [1:0] m,
      input sgc_pkg::sgc_port_stat_s s);
    return {m == 2'h0 ? s.speed100 : m == 2'h1 ? s.activity : s.full_duplex,
      m[0] ? s.link : s.link & ~s.activity};
  endfunction

  initial begin
    #100000;
    err_count++;
    stop_test;
  end

  initial begin
    for (int s = 0; s < 2; s++) begin
      rst <= 1'b1;
      io_low_voltage <= s[0];
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      w = s[0] ? 16'h0847 : 16'h0827;
      rd(sgc_pkg::OFS_GCTRL7, w);
    end
    rd(12'h00C, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      w = 16'($random(seed));
      mac = {mac[31:0], w};
      wr(12'h010 + 12'(2 * i), w);
    end
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(psa, mac);
    for (int i = 0; i < 3; i++)
      rd(12'h010 + 12'(2 * i), mac[47 - 16 * i -: 16]);
    for (int e = 0; e < 2; e++) begin
      for (int p = 0; p < 3; p++) begin
        w = {6'h02, 2'h0, e[0], 2'h1, 2'h0, 3'($random(seed))};
        wr(sgc_pkg::OFS_GCTRL7, w);
        miss(2'(p), e[0] ? w[2:0] : ~(3'h1 << p));
      end
    end
    rd(sgc_pkg::OFS_GCTRL7, w);
    for (int m = 0; m < 4; m++) begin
      port_stat <= 8'($random(seed));
      wr(sgc_pkg::OFS_GCTRL7, {6'h02, 2'(m), 1'b0, 2'h1, 2'h0, 3'h7});
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      for (int p = 0; p < 2; p++)
        chk(48'({led_one[p], led_zero[p]}),
          48'(led_exp(2'(m), port_stat[p])));
    end
    // processor takes port 1 leds, port 2 stays automatic
    wr(sgc_pkg::OFS_P1_LED_CTRL, 16'h1002);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(48'({led_one[0], led_zero[0]}), 48'h2);
    chk(48'({led_one[1], led_zero[1]}),
      48'(led_exp(2'h3, port_stat[1])));
    stop_test;
  end
endmodule
